// ===== rtl/ircm_pkg.sv
// Package of constants for the iso receive context match filter
package ircm_pkg;
  localparam int          IRCM_NUM_CTX       = 4;
  localparam logic [11:0] IRCM_FILTER_BASE   = 12'h410;
  localparam logic [11:0] IRCM_CTX_STRIDE    = 12'h020;
  // Extra per-context control word; bit layout chosen for this block
  localparam logic [11:0] IRCM_CTRL_BASE     = 12'h414;
  localparam int          IRCM_CTRL_START_EN = 0;
  localparam int          IRCM_CTRL_WAIT_LO  = 1;
  localparam int          IRCM_CTRL_WAIT_HI  = 2;
  localparam int          IRCM_CTRL_RUNNING  = 3;
  localparam logic [1:0]  IRCM_WAIT_SYNC     = 2'h3;
  // Field positions of the filter register
  localparam int          IRCM_ACCEPT_TAG_VALUE_THREE_BIT      = 31;
  localparam int          IRCM_ACCEPT_TAG_VALUE_TWO_BIT      = 30;
  localparam int          IRCM_ACCEPT_TAG_VALUE_ONE_BIT      = 29;
  localparam int          IRCM_ACCEPT_TAG_VALUE_ZERO_BIT      = 28;
  localparam int          IRCM_CYC_HI        = 26;
  localparam int          IRCM_CYC_LO        = 12;
  localparam int          IRCM_SYNC_HI       = 11;
  localparam int          IRCM_SYNC_LO       = 8;
  localparam int          IRCM_PREFIX_BIT    = 6;
  localparam int          IRCM_CHAN_HI       = 5;
  localparam int          IRCM_CHAN_LO       = 0;
  // Writable bits; 27 and 7 read as zero
  localparam logic [31:0] IRCM_FILTER_MASK   = 32'hF7FFFF7F;
  localparam logic [31:0] IRCM_FILTER_RESET  = 32'h00000000;
  localparam logic [3:0]  IRCM_CTRL_MASK     = 4'h7;
  localparam logic [1:0]  IRCM_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  IRCM_HSIZE_WORD    = 3'h2;
endpackage

// ===== rtl/ircm_pkt_if.sv
// Interface carrying one received packet header to each context matcher
`timescale 1ns/10ps
interface ircm_pkt_if;
  logic        valid;
  logic [1:0]  tag;
  logic [5:0]  channel;
  logic [3:0]  sync;
  logic [14:0] cycle_now;
  modport src (output valid, output tag, output channel, output sync,
               output cycle_now);
  modport dst (input valid, input tag, input channel, input sync,
               input cycle_now);
endinterface

// ===== rtl/ircm_ctx_match.sv
// Single context packet matcher with start-on-cycle arming
`timescale 1ns/10ps
module ircm_ctx_match
  import ircm_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Packet header
  ircm_pkt_if.dst          pkt,
  // Configuration
  input  wire logic [31:0] filter,
  input  wire logic [2:0]  ctrl,
  // Status
  output logic             running,
  output logic             hit
);
  typedef struct packed {
    logic running;
    logic start_en;
  } ircm_ctx_s;

  ircm_ctx_s st_q;
  ircm_ctx_s st_d;
  logic      tag_ok;
  logic      sync_ok;
  logic      cyc_hit;

  // Tag, sync and cycle timer qualification of the current header
  always_comb begin
    unique case (pkt.tag)
      2'h3: tag_ok = filter[IRCM_ACCEPT_TAG_VALUE_THREE_BIT]; // [R2] [R12]
      2'h2: tag_ok = filter[IRCM_ACCEPT_TAG_VALUE_TWO_BIT]; // [R3] [R12]
      2'h1: tag_ok = filter[IRCM_ACCEPT_TAG_VALUE_ONE_BIT] &&
                     (!filter[IRCM_PREFIX_BIT] ||
                      pkt.sync[3:2] == 2'h0); // [R4] [R11] [R13]
      2'h0: tag_ok = filter[IRCM_ACCEPT_TAG_VALUE_ZERO_BIT]; // [R5] [R12]
    endcase
    sync_ok = (ctrl[IRCM_CTRL_WAIT_HI:IRCM_CTRL_WAIT_LO] != IRCM_WAIT_SYNC) ||
              (pkt.sync == filter[IRCM_SYNC_HI:IRCM_SYNC_LO]); // [R9]
    cyc_hit = pkt.cycle_now == filter[IRCM_CYC_HI:IRCM_CYC_LO]; // [R8]
  end

  // Context arms on the chosen cycle when start-on-cycle is set
  always_comb begin
    st_d          = st_q;
    st_d.start_en = ctrl[IRCM_CTRL_START_EN];
    if (!ctrl[IRCM_CTRL_START_EN]) begin
      st_d.running = 1'b1;
    end else if (!st_q.start_en) begin
      // Newly armed: hold off unless the timer already matches
      st_d.running = cyc_hit; // [R8]
    end else if (cyc_hit) begin
      st_d.running = 1'b1; // [R8]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign running = st_q.running;
  // Route only when every condition holds
  assign hit = pkt.valid && st_q.running && tag_ok && sync_ok &&
               pkt.channel == filter[IRCM_CHAN_HI:IRCM_CHAN_LO]; // [R14] [R15]
endmodule

// ===== rtl/ircm_top.sv
// Iso receive context match filter with AHB-Lite register slave
//
// Contract
// R1 - Four context filter registers, 32-byte stride
// R2 - Tag-three enable accepts tag 11
// R3 - Tag-two enable accepts tag 10
// R4 - Tag-one enable accepts tag 01, prefix-filtered
// R5 - Tag-zero enable accepts tag 00
// R6 - Bit 27 reads zero
// R7 - Bits 26..12 hold writable start cycle
// R8 - Start-on-cycle waits for cycle timer match
// R9 - Sync field compared when wait equals 11
// R10 - Bit 7 reads zero
// R11 - Prefix filter needs sync top bits zero
// R12 - Prefix filter ignores non tag-one packets
// R13 - Without prefix filter, tag enables alone
// R14 - Bits 5..0 channel; only that channel accepted
// R15 - Route needs channel, tag, sync, cycle
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/10ps
module ircm_top
  import ircm_pkg::*;
#(
  parameter int NUM_CTX = IRCM_NUM_CTX
)(
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [11:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Received header and cycle timer
  input  wire logic              pkt_valid,
  input  wire logic [1:0]        pkt_tag,
  input  wire logic [5:0]        pkt_channel,
  input  wire logic [3:0]        pkt_sync,
  input  wire logic [1:0]        bus_seconds_count,
  input  wire logic [12:0]       bus_cycle_number,
  // Routing result
  output logic [NUM_CTX-1:0]     ctx_hit
);
  initial begin
    if (NUM_CTX < 1 || NUM_CTX > IRCM_NUM_CTX) begin
      $error("NUM_CTX out of range");
    end
  end

  typedef struct packed {
    logic [NUM_CTX-1:0][31:0] filter;
    logic [NUM_CTX-1:0][2:0]  ctrl;
    logic                     wr_pend;
    logic                     sel_filt;
    logic [1:0]               ctx_idx;
    logic                     hit_map;
    logic [31:0]              rdata;
    logic [NUM_CTX-1:0]       hit;
  } ircm_top_s;

  ircm_top_s          st_q;
  ircm_top_s          st_d;
  logic [NUM_CTX-1:0] hit_w;
  logic [NUM_CTX-1:0] run_w;
  logic               acc;
  logic [11:0]        off;
  logic [1:0]         idx;
  logic               is_filt;
  logic               is_ctrl;
  logic               mapped;

  ircm_pkt_if pkt_bus ();
  assign pkt_bus.valid     = pkt_valid;
  assign pkt_bus.tag       = pkt_tag;
  assign pkt_bus.channel   = pkt_channel;
  assign pkt_bus.sync      = pkt_sync;
  assign pkt_bus.cycle_now = {bus_seconds_count, bus_cycle_number}; // [R7]

  // One matcher per context
  genvar g;
  generate
    for (g = 0; g < NUM_CTX; g++) begin : g_ctx
      ircm_ctx_match u_match (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pkt     (pkt_bus),
        .filter  (st_q.filter[g]),
        .ctrl    (st_q.ctrl[g]),
        .running (run_w[g]),
        .hit     (hit_w[g])
      );
    end
  endgenerate

  // Address decode of the address phase
  always_comb begin
    acc     = hsel && hready && htrans == IRCM_HTRANS_NONSEQ;
    off     = haddr - IRCM_FILTER_BASE;
    idx     = off[6:5];
    is_filt = haddr >= IRCM_FILTER_BASE && off[4:0] == 5'h00 &&
              off < 12'(NUM_CTX * 32); // [R1]
    is_ctrl = haddr >= IRCM_FILTER_BASE && off[4:0] == 5'h04 &&
              off < 12'(NUM_CTX * 32);
    mapped  = is_filt || is_ctrl;
  end

  // Register file, read mux and hit registering
  always_comb begin
    st_d     = st_q;
    st_d.hit = hit_w;
    if (st_q.wr_pend && st_q.hit_map) begin
      if (st_q.sel_filt) begin
        st_d.filter[st_q.ctx_idx] = hwdata & IRCM_FILTER_MASK; // [R6] [R10]
      end else begin
        st_d.ctrl[st_q.ctx_idx] = hwdata[2:0] & IRCM_CTRL_MASK[2:0];
      end
    end
    st_d.wr_pend = 1'b0;
    if (acc) begin
      st_d.wr_pend  = hwrite;
      st_d.sel_filt = is_filt;
      st_d.ctx_idx  = idx;
      st_d.hit_map  = mapped && hsize == IRCM_HSIZE_WORD;
      st_d.rdata    = 32'h00000000;
      if (!hwrite && mapped) begin
        if (is_filt) begin
          st_d.rdata = st_q.filter[idx] & IRCM_FILTER_MASK; // [R6] [R10]
        end else begin
          st_d.rdata = {28'h0000000, run_w[idx], st_q.ctrl[idx]};
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_q.rdata;
  assign ctx_hit   = st_q.hit; // [R15]
endmodule

// ===== verification/ircm_checker.sv
// Bus and routing checker for the context match filter
`timescale 1ns/10ps
module ircm_checker #(
  parameter int NUM_CTX = 4
)(
  // Clock and reset
  input wire logic               hclk,
  input wire logic               hresetn,
  // Bus and routing ports
  input wire logic               hsel,
  input wire logic [11:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic [31:0]        hrdata,
  input wire logic               pkt_valid,
  input wire logic [NUM_CTX-1:0] ctx_hit
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Accepted read address phase at one address
  sequence s_rd(logic [11:0] a);
    hsel && htrans == 2'h2 && !hwrite && haddr == a;
  endsequence
  a_ready_high: assert property (hreadyout)
    else $error("wait state seen");
  a_resp_okay: assert property (!hresp)
    else $error("error response seen");
  a_bit27_zero: assert property (!hrdata[27])
    else $error("bit 27 read as one");
  a_bit7_zero: assert property (!hrdata[7])
    else $error("bit 7 read as one");
  a_unmapped_zero: assert property (s_rd(12'h400) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_narrow: assert property (s_rd(12'h414) |=> hrdata[31:4] == 28'h0)
    else $error("control read too wide");
  a_rdata_hold: assert property (!(hsel && htrans == 2'h2) |=> $stable(hrdata))
    else $error("read data moved");
  a_hit_cause: assert property (ctx_hit != '0 |-> $past(pkt_valid))
    else $error("hit without header");
endmodule
bind ircm_top ircm_checker #(.NUM_CTX(NUM_CTX)) chk_u (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hreadyout, .hresp, .hrdata,
  .pkt_valid, .ctx_hit);

// ===== verification/ircm_hdr_src.sv
// Link receive path model presenting one header per call
`timescale 1ns/10ps
module ircm_hdr_src (
  // Clock
  input wire logic hclk,
  // Header to the filter
  output logic       pkt_valid,
  output logic [1:0] pkt_tag,
  output logic [5:0] pkt_channel,
  output logic [3:0] pkt_sync
);
  // Idle at time zero
  initial begin
    pkt_valid = 1'b0;
    {pkt_tag, pkt_channel, pkt_sync} = 12'h0;
  end
  // Header for one cycle after a gap; fields scrambled once released
  task automatic send(input logic [1:0] t, input logic [5:0] c,
                      input logic [3:0] s, input int gap);
    repeat (gap) @(posedge hclk);
    pkt_valid <= 1'b1;
    {pkt_tag, pkt_channel, pkt_sync} <= {t, c, s};
    @(posedge hclk);
    pkt_valid <= 1'b0;
    {pkt_tag, pkt_channel, pkt_sync} <= ~{t, c, s};
  endtask
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the context match filter
`timescale 1ns/10ps
module testbench;
  logic        hclk, hresetn, hsel, hwrite, pkt_valid;
  logic [11:0] haddr;
  logic [1:0]  htrans, pkt_tag, bus_seconds_count;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic [5:0]  pkt_channel;
  logic [3:0]  pkt_sync, ctx_hit;
  logic [12:0] bus_cycle_number;
  wire         hready, hreadyout, hresp;
  int          errors, checked;
  assign hready = hreadyout;
  ircm_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pkt_valid,
    .pkt_tag, .pkt_channel, .pkt_sync, .bus_seconds_count,
    .bus_cycle_number, .ctx_hit);
  ircm_hdr_src src_u (.hclk, .pkt_valid, .pkt_tag, .pkt_channel,
    .pkt_sync);
  // Clock at 200 MHz
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Free-running cycle timer
  always @(posedge hclk) begin
    {bus_seconds_count, bus_cycle_number} <=
      {bus_seconds_count, bus_cycle_number} + 15'h1;
  end
  task automatic end_of_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR %0t: got %h want %h", $time, s, e);
    end
  endtask
  // Bounded wait for hready at a rising edge
  task automatic rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 64) begin
      n++;
      @(posedge hclk);
    end
    if (n == 64) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    {hsel, htrans, hwrite, haddr} <= {3'h6, w, a};
    rdy();
    {hsel, htrans, hwdata} <= {3'h0, d};
    rdy();
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  // Send a header and judge the routing bit of context n
  task automatic pk(input int n, input logic [1:0] t, input logic [5:0] c,
                    input logic [3:0] s, input logic e);
    src_u.send(t, c, s, n % 2);
    #1;
    chk({31'h0, ctx_hit[n]}, {31'h0, e});
  endtask
  task automatic t_regs();
    for (int n = 0; n < 4; n++) begin
      rc(12'h410 + 12'(32 * n), 32'h0);
      wr(12'h410 + 12'(32 * n), 32'hFFFFFFFF);
      rc(12'h410 + 12'(32 * n), 32'hF7FFFF7F);
      wr(12'h410 + 12'(32 * n), 32'h0);
    end
    wr(12'h400, 32'hFFFFFFFF);
    rc(12'h400, 32'h0);
    rc(12'h414, 32'h8);
    $display("registers done");
  endtask
  task automatic t_tags();
    for (int e = 0; e < 4; e++) begin
      wr(12'h410, (32'h1 << (28 + e)) | 32'h5);
      for (int t = 0; t < 4; t++)
        pk(0, 2'(t), 6'h05, 4'hC, e == t);
      pk(0, 2'(e), 6'h06, 4'h0, 1'b0);
    end
    $display("tags done");
  endtask
  task automatic t_prefix();
    wr(12'h430, 32'h30000049);
    pk(1, 2'h1, 6'h09, 4'h3, 1'b1);
    pk(1, 2'h1, 6'h09, 4'h4, 1'b0);
    pk(1, 2'h1, 6'h09, 4'h8, 1'b0);
    pk(1, 2'h0, 6'h09, 4'hC, 1'b1);
    pk(1, 2'h3, 6'h09, 4'h0, 1'b0);
    $display("prefix done");
  endtask
  task automatic t_sync();
    wr(12'h450, 32'h10000A03);
    wr(12'h454, 32'h6);
    pk(2, 2'h0, 6'h03, 4'hA, 1'b1);
    pk(2, 2'h0, 6'h03, 4'h5, 1'b0);
    wr(12'h454, 32'h0);
    pk(2, 2'h0, 6'h03, 4'h5, 1'b1);
    $display("sync done");
  endtask
  // Context 3 held off until the cycle timer reaches the chosen value
  task automatic t_cycle();
    logic [14:0] tgt;
    int          n;
    tgt = {bus_seconds_count, bus_cycle_number} + 15'd40;
    wr(12'h470, 32'h10000007 | {5'h0, tgt, 12'h000});
    wr(12'h474, 32'h1);
    pk(3, 2'h0, 6'h07, 4'h0, 1'b0);
    rc(12'h474, 32'h1);
    n = 0;
    while ({bus_seconds_count, bus_cycle_number} !== tgt && n < 100) begin
      n++;
      @(posedge hclk);
    end
    if (n == 100) begin
      errors++;
      end_of_test();
    end
    pk(3, 2'h0, 6'h07, 4'h0, 1'b1);
    $display("cycle done");
  endtask
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = 49'h0;
    {bus_seconds_count, bus_cycle_number} = 15'h0;
    hsize = 3'h2;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_tags();
    t_prefix();
    t_sync();
    t_cycle();
    end_of_test();
  end
endmodule
